// ==== include/rpf_defines.svh ====
// Constants for the receive packet filter: register map, field positions,
// reset values and frame layout. Included by the design; the package does not include it.
`ifndef RPF_DEFINES_SVH
`define RPF_DEFINES_SVH

// Register byte offsets on the APB
`define RPF_OFS_CTRL 12'h000
`define RPF_OFS_ADDR_LO 12'h004
`define RPF_OFS_ADDR_HI 12'h008
`define RPF_OFS_WIN_OFS 12'h00c
`define RPF_OFS_MASK_LO 12'h010
`define RPF_OFS_MASK_HI 12'h014
`define RPF_OFS_CSUM 12'h018
`define RPF_OFS_HASH_LO 12'h01c
`define RPF_OFS_HASH_HI 12'h020
`define RPF_OFS_STATUS 12'h024

// Control register fields
`define RPF_BIT_UC 7
`define RPF_BIT_COMB 6
`define RPF_BIT_CRC 5
`define RPF_BIT_PM 4
`define RPF_BIT_WK 3
`define RPF_BIT_HT 2
`define RPF_BIT_MC 1
`define RPF_BIT_BC 0
`define RPF_CTRL_RESET 8'ha1
`define RPF_FILTER_BITS 8'h9f

// Frame layout
`define RPF_DA_LEN 16'h0006
`define RPF_DATA_START 16'h000e
`define RPF_WIN_LEN 17'h00040
`define RPF_SYNC_LEN 3'h6
`define RPF_ADDR_LAST 3'h5
`define RPF_WAKE_LAST 7'h5f
`define RPF_BYTE_ONES 8'hff
`define RPF_POS_MAX 16'hffff

// Destination address hash
`define RPF_CRC_INIT 32'hffffffff
`define RPF_CRC_POLY 32'hedb88320
`define RPF_HASH_MSB 28
`define RPF_HASH_LSB 23

// Stream word layout in the FIFO
`define RPF_FIFO_WIDTH 10
`define RPF_FIFO_DEPTH 8
`define RPF_FW_LAST 9
`define RPF_FW_CRCOK 8

`endif

// ==== include/rpf_pkg.sv ====
// Types shared by the receive packet filter.
// Assumes rpf_defines.svh is on the include path.
package rpf_pkg;
    typedef enum logic [1:0] {
        WK_SEARCH = 2'b00,
        WK_MATCH = 2'b01,
        WK_FOUND = 2'b10
    } rpf_wake_t;
endpackage

// ==== hdl/rpf_filter.sv ====
// Receive packet filter: byte FIFO and the frame accept/discard logic with
// its APB register file.
// Assumes a byte stream on mclk from the receive path and an APB master.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rpf_defines.svh"
`default_nettype none

module rpf_fifo #(
    parameter int WIDTH = `RPF_FIFO_WIDTH,
    parameter int DEPTH = `RPF_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    wire full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    wire empty = (wrPtr_q == rdPtr_q);
    wire push = inValid && !full;
    wire pop = outReady && !empty;

    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end
endmodule

module rpf_filter (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxValid,
    output logic rxReady,
    input wire logic [7:0] rxData,
    input wire logic rxLast,
    input wire logic rxCrcOk,
    output logic resultValid,
    input wire logic resultReady,
    output logic resultAccept,
    output logic [7:0] resultFlags
);
    // Byte idx of a 48-bit address, byte 0 being the first on the wire
    function automatic logic [7:0] addrByte(input logic [47:0] addr, input logic [2:0] idx);
        addrByte = addr[idx*8 +: 8];
    endfunction

    // Reflected CRC-32 over one byte
    function automatic logic [31:0] crcByte(input logic [31:0] crc, input logic [7:0] data);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ data[i]) ? ((c >> 1) ^ `RPF_CRC_POLY) : (c >> 1);
        end
        crcByte = c;
    endfunction

    // Ones' complement add with end-around carry
    function automatic logic [15:0] csumAdd(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        csumAdd = s[15:0] + {15'h0000, s[16]};
    endfunction

    // Registers
    logic [7:0] ctrl_q;
    logic [47:0] addr_q;
    logic [15:0] winOfs_q;
    logic [63:0] mask_q;
    logic [15:0] csExp_q;
    logic [63:0] hash_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // APB decode
    wire setup = psel && !penable;
    wire wrEn = psel && penable && pwrite;
    wire hitCtrl = (paddr == `RPF_OFS_CTRL);
    wire hitAddrLo = (paddr == `RPF_OFS_ADDR_LO);
    wire hitAddrHi = (paddr == `RPF_OFS_ADDR_HI);
    wire hitWinOfs = (paddr == `RPF_OFS_WIN_OFS);
    wire hitMaskLo = (paddr == `RPF_OFS_MASK_LO);
    wire hitMaskHi = (paddr == `RPF_OFS_MASK_HI);
    wire hitCsum = (paddr == `RPF_OFS_CSUM);
    wire hitHashLo = (paddr == `RPF_OFS_HASH_LO);
    wire hitHashHi = (paddr == `RPF_OFS_HASH_HI);
    wire hitStatus = (paddr == `RPF_OFS_STATUS);
    wire hitAny = hitCtrl || hitAddrLo || hitAddrHi || hitWinOfs || hitMaskLo || hitMaskHi
        || hitCsum || hitHashLo || hitHashHi || hitStatus;
    wire [31:0] rdMux =
        hitCtrl ? {24'h000000, ctrl_q} :
        hitAddrLo ? addr_q[31:0] :
        hitAddrHi ? {16'h0000, addr_q[47:32]} :
        hitWinOfs ? {16'h0000, winOfs_q} :
        hitMaskLo ? mask_q[31:0] :
        hitMaskHi ? mask_q[63:32] :
        hitCsum ? {16'h0000, csExp_q} :
        hitHashLo ? hash_q[31:0] :
        hitHashHi ? hash_q[63:32] :
        hitStatus ? {23'h000000, resultValid, resultFlags} :
        32'h00000000;

    assign pready = psel && penable;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h00000000 : rdMux;
            pslverr_q <= !hitAny;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `RPF_CTRL_RESET;
            addr_q <= '0;
            winOfs_q <= '0;
            mask_q <= '0;
            csExp_q <= '0;
            hash_q <= '0;
        end else if (wrEn) begin
            if (hitCtrl) ctrl_q <= pwdata[7:0];
            if (hitAddrLo) addr_q[31:0] <= pwdata;
            if (hitAddrHi) addr_q[47:32] <= pwdata[15:0];
            if (hitWinOfs) winOfs_q <= pwdata[15:0];
            if (hitMaskLo) mask_q[31:0] <= pwdata;
            if (hitMaskHi) mask_q[63:32] <= pwdata;
            if (hitCsum) csExp_q <= pwdata[15:0];
            if (hitHashLo) hash_q[31:0] <= pwdata;
            if (hitHashHi) hash_q[63:32] <= pwdata;
        end
    end

    // Byte buffer between the receive path and the filter
    logic fifoValid;
    logic [`RPF_FIFO_WIDTH-1:0] fifoData;
    logic finish_q;
    logic resultValid_q;
    wire fifoReady = !finish_q && !resultValid_q;
    wire take = fifoValid && fifoReady;

    rpf_fifo #(
        .WIDTH(`RPF_FIFO_WIDTH),
        .DEPTH(`RPF_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .inValid(rxValid),
        .inReady(rxReady),
        .inData({rxLast, rxCrcOk, rxData}),
        .outValid(fifoValid),
        .outReady(fifoReady),
        .outData(fifoData)
    );

    wire [7:0] rxByte = fifoData[7:0];
    wire byteLast = fifoData[`RPF_FW_LAST];
    wire isOnes = (rxByte == `RPF_BYTE_ONES);

    // Frame position; after the last byte it holds the frame length
    logic [15:0] pos_q;
    logic crcOk_q;
    wire inDa = (pos_q < `RPF_DA_LEN);
    wire daFull = (pos_q >= `RPF_DA_LEN);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pos_q <= '0;
            finish_q <= 1'b0;
            crcOk_q <= 1'b0;
        end else begin
            finish_q <= take && byteLast;
            if (finish_q) begin
                pos_q <= '0;
            end else if (take && pos_q != `RPF_POS_MAX) begin
                pos_q <= pos_q + 16'h0001;
            end
            if (take && byteLast) begin
                crcOk_q <= fifoData[`RPF_FW_CRCOK];
            end
        end
    end

    // Destination address checks and hash CRC
    logic ucMiss_q;
    logic bcMiss_q;
    logic mcHit_q;
    logic [31:0] crc_q;
    wire daMismatch = (rxByte != addrByte(addr_q, pos_q[2:0]));

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ucMiss_q <= 1'b0;
            bcMiss_q <= 1'b0;
            mcHit_q <= 1'b0;
            crc_q <= `RPF_CRC_INIT;
        end else if (finish_q) begin
            ucMiss_q <= 1'b0;
            bcMiss_q <= 1'b0;
            mcHit_q <= 1'b0;
            crc_q <= `RPF_CRC_INIT;
        end else if (take && inDa) begin
            ucMiss_q <= ucMiss_q || daMismatch;
            bcMiss_q <= bcMiss_q || !isOnes;
            crc_q <= crcByte(crc_q, rxByte);
            if (pos_q == 16'h0000) begin
                mcHit_q <= rxByte[0];
            end
        end
    end

    // Pattern window checksum
    logic [15:0] sum_q;
    logic [7:0] hiByte_q;
    logic hiPend_q;
    wire [16:0] winEnd = {1'b0, winOfs_q} + `RPF_WIN_LEN;
    wire inWin = (pos_q >= winOfs_q) && ({1'b0, pos_q} < winEnd);
    wire [15:0] winIdx = pos_q - winOfs_q;
    wire winSel = inWin && mask_q[winIdx[5:0]];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sum_q <= '0;
            hiByte_q <= '0;
            hiPend_q <= 1'b0;
        end else if (finish_q) begin
            sum_q <= '0;
            hiPend_q <= 1'b0;
        end else if (take && winSel) begin
            // Only selected bytes advance the pairing
            if (hiPend_q) begin
                sum_q <= csumAdd(sum_q, {hiByte_q, rxByte});
                hiPend_q <= 1'b0;
            end else begin
                hiByte_q <= rxByte;
                hiPend_q <= 1'b1;
            end
        end
    end

    // Odd byte left over is padded with a zero low byte
    wire [15:0] sumFinal = hiPend_q ? csumAdd(sum_q, {hiByte_q, 8'h00}) : sum_q;
    wire [15:0] csumCalc = ~sumFinal;
    wire winFits = (winEnd <= {1'b0, pos_q});
    wire pmPass = winFits && (csumCalc == csExp_q);

    // Wake frame search in the data field
    rpf_pkg::rpf_wake_t wkState_q;
    logic [2:0] syncCnt_q;
    logic [2:0] addrIdx_q;
    logic [6:0] wkCnt_q;
    wire wkActive = take && (pos_q >= `RPF_DATA_START);
    wire wkExpHit = (rxByte == addrByte(addr_q, addrIdx_q));
    wire wkFirstHit = (rxByte == addrByte(addr_q, 3'h0));

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wkState_q <= rpf_pkg::WK_SEARCH;
            syncCnt_q <= '0;
            addrIdx_q <= '0;
            wkCnt_q <= '0;
        end else if (finish_q) begin
            wkState_q <= rpf_pkg::WK_SEARCH;
            syncCnt_q <= '0;
            addrIdx_q <= '0;
            wkCnt_q <= '0;
        end else if (wkActive) begin
            case (wkState_q)
                rpf_pkg::WK_SEARCH: begin
                    if (isOnes) begin
                        if (syncCnt_q != `RPF_SYNC_LEN) syncCnt_q <= syncCnt_q + 3'h1;
                    end else if (syncCnt_q == `RPF_SYNC_LEN && wkFirstHit) begin
                        wkState_q <= rpf_pkg::WK_MATCH;
                        wkCnt_q <= 7'h01;
                        addrIdx_q <= 3'h1;
                    end else begin
                        syncCnt_q <= '0;
                    end
                end
                rpf_pkg::WK_MATCH: begin
                    if (!wkExpHit) begin
                        wkState_q <= rpf_pkg::WK_SEARCH;
                        syncCnt_q <= isOnes ? 3'h1 : 3'h0;
                    end else if (wkCnt_q == `RPF_WAKE_LAST) begin
                        wkState_q <= rpf_pkg::WK_FOUND;
                    end else begin
                        wkCnt_q <= wkCnt_q + 7'h01;
                        addrIdx_q <= (addrIdx_q == `RPF_ADDR_LAST) ? 3'h0 : addrIdx_q + 3'h1;
                    end
                end
                rpf_pkg::WK_FOUND: begin
                    wkState_q <= rpf_pkg::WK_FOUND;
                end
                default: begin
                    wkState_q <= rpf_pkg::WK_SEARCH;
                end
            endcase
        end
    end

    // Filter results and combination
    wire ucPass = daFull && !ucMiss_q;
    wire bcPass = daFull && !bcMiss_q;
    wire mcPass = mcHit_q;
    wire [5:0] hashIdx = crc_q[`RPF_HASH_MSB:`RPF_HASH_LSB];
    wire htPass = daFull && hash_q[hashIdx];
    wire wkPass = ucPass && (wkState_q == rpf_pkg::WK_FOUND);
    wire [7:0] passVec = {ucPass, 2'b00, pmPass, wkPass, htPass, mcPass, bcPass};
    wire [7:0] filtEn = ctrl_q & `RPF_FILTER_BITS;
    wire anyEn = |filtEn;
    wire andOk = &(~filtEn | passVec);
    wire orOk = |(filtEn & passVec);
    wire combOk = !anyEn || (ctrl_q[`RPF_BIT_COMB] ? andOk : orOk);
    wire crcFail = ctrl_q[`RPF_BIT_CRC] && !crcOk_q;
    wire acceptNow = combOk && !crcFail;

    logic resultAccept_q;
    logic [7:0] resultFlags_q;
    assign resultValid = resultValid_q;
    assign resultAccept = resultAccept_q;
    assign resultFlags = resultFlags_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            resultValid_q <= 1'b0;
            resultAccept_q <= 1'b0;
            resultFlags_q <= '0;
        end else if (finish_q) begin
            resultValid_q <= 1'b1;
            resultAccept_q <= acceptNow;
            resultFlags_q <= {passVec[7], crcOk_q, 1'b0, passVec[4:0]};
        end else if (resultReady) begin
            resultValid_q <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ==== bench/rpf_filter_asserts.sv ====
// Port checker for rpf_filter, bound to every instance.
// Assumes the register map and result handshake given with the design.
`timescale 1ns/1ps
`default_nettype none
module rpf_filter_asserts (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic [7:0] rxData,
    input wire logic rxLast,
    input wire logic rxCrcOk,
    input wire logic resultValid,
    input wire logic resultReady,
    input wire logic resultAccept,
    input wire logic [7:0] resultFlags
);
    logic [7:0] ctrl_q;
    logic [7:0] flt;
    logic crcBad;
    // Shadow of the control register, kept from APB writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 8'ha1;
        end else if (psel && penable && pwrite && paddr == 12'h000) begin
            ctrl_q <= pwdata[7:0];
        end
    end
    assign flt = ctrl_q & 8'h9f;
    assign crcBad = ctrl_q[5] && !resultFlags[6];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    zero_wait_a: assert property (pready == (psel && penable))
        else $error("pready not equal to access phase");
    unmapped_err_a: assert property (psel && penable && paddr > 12'h024 |-> pslverr)
        else $error("no slave error on unmapped address");
    status_read_a: assert property (psel && penable && !pwrite && paddr == 12'h024 |->
        prdata[8:0] == {$past(resultValid), $past(resultFlags)})
        else $error("status read mismatch");
    result_hold_a: assert property (resultValid && !resultReady |=>
        resultValid && $stable(resultAccept) && $stable(resultFlags))
        else $error("result changed before it was taken");
    result_drop_a: assert property (resultValid && resultReady |=> !resultValid)
        else $error("result not released");
    and_mode_a: assert property (resultValid && ctrl_q[6] |->
        resultAccept == ((flt & ~resultFlags) == 8'h00 && !crcBad))
        else $error("AND combine wrong");
    or_mode_a: assert property (resultValid && !ctrl_q[6] |->
        resultAccept == ((flt == 8'h00 || (flt & resultFlags) != 8'h00) && !crcBad))
        else $error("OR combine wrong");
    crc_discard_a: assert property (resultValid && crcBad |-> !resultAccept)
        else $error("bad CRC frame kept");
    promisc_a: assert property (resultValid && ctrl_q == 8'h00 |-> resultAccept)
        else $error("frame dropped with filters off");
    cover property (resultValid && resultAccept);
    cover property (resultValid && !resultAccept);
    cover property (!rxReady);
endmodule
bind rpf_filter rpf_filter_asserts u_rpf_filter_asserts (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData), .rxLast(rxLast), .rxCrcOk(rxCrcOk),
    .resultValid(resultValid), .resultReady(resultReady), .resultAccept(resultAccept),
    .resultFlags(resultFlags));
`default_nettype wire

// ==== bench/rpf_rx_source.sv ====
// Frame source standing in for the receive datapath.
// Assumes a byte is taken at a rising edge with rxValid and rxReady high.
`timescale 1ns/1ps
`default_nettype none
module rpf_rx_source (
    input wire logic mclk,
    input wire logic rxReady,
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxLast,
    output logic rxCrcOk
);
    initial begin
        rxValid = 1'b0;
        rxData = 8'h5a;
        rxLast = 1'b0;
        rxCrcOk = 1'b0;
    end
    // Holds each byte until taken; idle lines show the inverse of the last value
    task automatic send(input logic [7:0] fr[$], input logic ok);
        @(posedge mclk);
        for (int i = 0; i < fr.size(); i++) begin
            rxValid <= 1'b1;
            rxData <= fr[i];
            rxLast <= (i == fr.size() - 1);
            rxCrcOk <= ok;
            // Byte is taken at the rising edge where rxReady is seen high
            do @(posedge mclk); while (rxReady !== 1'b1);
        end
        rxValid <= 1'b0;
        rxData <= ~fr[fr.size() - 1];
        rxLast <= 1'b0;
        rxCrcOk <= ~ok;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_rpf_filter.sv ====
// Self-checking bench for rpf_filter: registers over APB, frames from the
// source model, accept or discard results compared with expectations.
`timescale 1ns/1ps
`default_nettype none
module tb_rpf_filter;
    localparam logic [47:0] ST = 48'h021122334455;
    localparam logic [47:0] OTH = 48'h021122334456;
    localparam logic [47:0] BC = 48'hffffffffffff;
    localparam logic [47:0] MC = 48'h01aabbccddee;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic resultReady = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, rxValid, rxReady, rxLast, rxCrcOk, resultValid, resultAccept;
    logic [7:0] rxData;
    logic [7:0] resultFlags;
    logic [7:0] fr[$];
    logic [32:0] rsp;
    logic [15:0] cs;
    logic [5:0] h;
    int n_errors = 0;
    int checks = 0;

    rpf_filter u_rpf_filter (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
        .rxLast(rxLast), .rxCrcOk(rxCrcOk), .resultValid(resultValid),
        .resultReady(resultReady), .resultAccept(resultAccept), .resultFlags(resultFlags));
    rpf_rx_source u_rpf_rx_source (.mclk(mclk), .rxReady(rxReady), .rxValid(rxValid),
        .rxData(rxData), .rxLast(rxLast), .rxCrcOk(rxCrcOk));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic stop_test();
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [32:0] r);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do @(posedge mclk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        logic [32:0] r;
        apb(1'b0, a, 32'h00000000, r);
        chk(r, e);
    endtask
    task automatic getres(input logic e);
        for (int i = 0; i < 300; i++) begin
            @(negedge mclk);
            if (resultValid === 1'b1) break;
        end
        chk({resultValid, resultAccept}, {1'b1, e});
        @(posedge mclk);
        resultReady <= 1'b1;
        @(posedge mclk);
        resultReady <= 1'b0;
    endtask
    task automatic mk(input logic [47:0] da, input int n);
        fr = {};
        for (int i = 0; i < n; i++) fr.push_back(i < 6 ? da[47 - 8 * i -: 8] : 8'(i * 5 + 1));
    endtask
    task automatic go(input logic e);
        u_rpf_rx_source.send(fr, 1'b1);
        getres(e);
    endtask
    task automatic tc(input logic [7:0] c, input logic [47:0] da, input logic ok, input logic e);
        wr(12'h000, {24'h000000, c});
        mk(da, 64);
        u_rpf_rx_source.send(fr, ok);
        getres(e);
    endtask
    task automatic ht(input logic [63:0] v, input logic e);
        wr(12'h01c, v[31:0]);
        wr(12'h020, v[63:32]);
        go(e);
    endtask
    task automatic pm(input logic [15:0] o, input logic [63:0] m, input logic [15:0] c,
                      input logic e);
        wr(12'h00c, {16'h0000, o});
        wr(12'h010, m[31:0]);
        wr(12'h014, m[63:32]);
        wr(12'h018, {16'h0000, c});
        go(e);
    endtask
    // Reflected CRC over the destination bytes, low bit first
    function automatic logic [5:0] hidx();
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++) begin
            c = (c[0] ^ fr[i / 8][i % 8]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        return c[28:23];
    endfunction
    function automatic logic [15:0] csum(input int off, input logic [63:0] m);
        logic [16:0] s;
        logic [7:0] b[$];
        s = 17'h00000;
        for (int i = 0; i < 64; i++) if (m[i]) b.push_back(fr[off + i]);
        if (b.size() % 2) b.push_back(8'h00);
        for (int k = 0; k < b.size(); k += 2) begin
            s = s[15:0] + {b[k], b[k + 1]};
            s = s[15:0] + s[16];
        end
        return ~s[15:0];
    endfunction

    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        rd(12'h000, 33'h0000000a1);
        rd(12'h00c, 33'h000000000);
        rd(12'h028, 33'h100000000);
        apb(1'b1, 12'h02c, 32'hffffffff, rsp);
        chk(rsp[32], 1'b1);
        wr(12'h004, 32'h33221102);
        wr(12'h008, 32'h00005544);
        wr(12'h000, 32'h0000005a);
        rd(12'h000, 33'h00000005a);
        tc(8'hc0, ST, 1'b1, 1'b1);
        tc(8'hc0, OTH, 1'b1, 1'b0);
        tc(8'h80, ST, 1'b1, 1'b1);
        tc(8'h80, OTH, 1'b1, 1'b0);
        tc(8'h81, BC, 1'b1, 1'b1);
        tc(8'h00, OTH, 1'b0, 1'b1);
        tc(8'h20, OTH, 1'b0, 1'b0);
        tc(8'ha1, ST, 1'b0, 1'b0);
        tc(8'h42, MC, 1'b1, 1'b1);
        tc(8'h42, OTH, 1'b1, 1'b0);
        tc(8'h41, BC, 1'b1, 1'b1);
        tc(8'h41, 48'hfffffffffffe, 1'b1, 1'b0);
        tc(8'h43, MC, 1'b1, 1'b0);
        tc(8'h03, MC, 1'b1, 1'b1);
        apb(1'b0, 12'h024, 32'h00000000, rsp);
        chk(rsp, 33'h000000042);
        wr(12'h000, 32'h00000044);
        mk(OTH, 64);
        h = hidx();
        ht(64'h0, 1'b0);
        ht(64'h1 << h, 1'b1);
        ht(~(64'h1 << h), 1'b0);
        ht('1, 1'b1);
        wr(12'h000, 32'h00000050);
        mk(OTH, 80);
        pm(16'h0010, 64'h0, 16'hffff, 1'b1);
        pm(16'h0011, 64'h0, 16'hffff, 1'b0);
        cs = csum(3, 64'h225);
        pm(16'h0003, 64'h225, cs, 1'b1);
        pm(16'h0003, 64'h225, cs ^ 16'h0001, 1'b0);
        wr(12'h000, 32'h00000048);
        mk(ST, 120);
        for (int i = 14; i < 116; i++) fr[i] = i < 20 ? 8'hff : fr[(i - 20) % 6];
        go(1'b1);
        fr[113] = 8'h00;
        go(1'b0);
        wr(12'h000, 32'h00000000);
        mk(ST, 64);
        fork
            begin
                u_rpf_rx_source.send(fr, 1'b1);
                u_rpf_rx_source.send(fr, 1'b1);
            end
        join_none
        repeat (150) @(posedge mclk);
        @(negedge mclk);
        chk(rxReady, 1'b0);
        getres(1'b1);
        getres(1'b1);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
